/* File: hw/pdc_config_word.sv */
/*
 Serial write-only configuration word zero: shift register, latch on the
 rising edge of the latch line, and reference status gating.
 Assumes the serial host and the reference monitor are asynchronous to mclk_i;
 all three serial lines and the monitor flag are resynchronised here.
 Limitation: the serial clock must hold each level for at least three mclk_i
 cycles, because its edges are found by sampling; the latch line likewise.
 Power-down is a level: a frame that ends while it is low is lost.
 Over-long frames keep their last 32 bits; short frames are dropped.
*/
`timescale 1ns/10ps
`include "pdc_params.svh"
module pdc_config_word
    import pdc_pkg::*;
(
    input wire logic mclk_i, // 200 MHz system clock
    input wire logic sys_rst_i, // async reset, active high
    input wire logic cfg_clk_i, // serial clock from host
    input wire logic cfg_data_i, // serial data from host
    input wire logic cfg_latch_enable_i, // low frames a word
    input wire logic power_down_n_i, // low restores defaults
    input wire logic ref_valid_i, // reference monitor: clock above 2 MHz
    output pdc_word0_type word0_o, // latched word zero fields
    output logic ref_status_o // reference status pin
);
    logic [2:0] clk_sync_q;
    logic [1:0] data_sync_q;
    logic [2:0] le_sync_q;
    logic [1:0] pd_sync_q;
    logic [1:0] valid_sync_q;
    logic [`PDC_WORD_BITS-1:0] shift_q;
    logic [5:0] count_q;
    pdc_state_type state_q;
    pdc_word0_type word0_q;
    logic ref_status_q;
    logic clk_rise;
    logic le_fall;
    logic le_rise;

    // two-flop resync; edge detect uses stages two and three only
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            clk_sync_q <= 3'h0;
            data_sync_q <= 2'h0;
            le_sync_q <= 3'h7;
            pd_sync_q <= 2'h0;
            valid_sync_q <= 2'h0;
        end else begin
            clk_sync_q <= {clk_sync_q[1:0], cfg_clk_i};
            data_sync_q <= {data_sync_q[0], cfg_data_i};
            le_sync_q <= {le_sync_q[1:0], cfg_latch_enable_i};
            pd_sync_q <= {pd_sync_q[0], power_down_n_i};
            valid_sync_q <= {valid_sync_q[0], ref_valid_i};
        end
    end

    // edges from settled stages only; stage three just holds history
    assign clk_rise = clk_sync_q[1] & ~clk_sync_q[2];
    assign le_fall = ~le_sync_q[1] & le_sync_q[2];
    assign le_rise = le_sync_q[1] & ~le_sync_q[2];

    // framing: shifting only while latch is low
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= PDC_IDLE;
        end else begin
            case (state_q)
                PDC_IDLE: begin
                    if (le_fall) begin
                        state_q <= PDC_SHIFT;
                    end
                end
                PDC_SHIFT: begin
                    if (le_rise) begin
                        state_q <= PDC_IDLE;
                    end
                end
                default: begin
                    state_q <= PDC_IDLE;
                end
            endcase
        end
    end

    // msb first shift; count saturates so over-long frames keep last 32 bits
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            shift_q <= 32'h0;
            count_q <= 6'h0;
        end else if (state_q == PDC_IDLE && le_fall) begin
            count_q <= 6'h0;
        end else if (state_q == PDC_SHIFT && clk_rise && !le_sync_q[1]) begin
            shift_q <= {shift_q[`PDC_WORD_BITS-2:0], data_sync_q[1]};
            if (count_q != `PDC_FRAME_COUNT) begin
                count_q <= count_q + 6'h01;
            end
        end
    end

    // word zero register; short frames are discarded as a guard
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            word0_q <= pdc_word0_type'(`PDC_WORD0_RST);
        end else if (!pd_sync_q[1]) begin
            word0_q <= pdc_word0_type'(`PDC_WORD0_RST);
        end else if (state_q == PDC_SHIFT && le_rise && count_q == `PDC_FRAME_COUNT &&
                     shift_q[`PDC_SEL_LSB+1:`PDC_SEL_LSB] == `PDC_SEL_WORD0) begin
            word0_q <= pdc_word0_type'(shift_q);
        end
    end

    // status pin: forced high when detection is off
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ref_status_q <= 1'h0;
        end else if (word0_q.ref_freq_detect_disable) begin
            ref_status_q <= 1'h1;
        end else begin
            ref_status_q <= valid_sync_q[1];
        end
    end

    // outputs straight from their registers
    assign word0_o = word0_q;
    assign ref_status_o = ref_status_q;

    // frame events seen on the resynchronised latch line
    sequence frame_end_s;
        state_q == PDC_SHIFT && le_rise && count_q == `PDC_FRAME_COUNT && shift_q[1:0] == 2'h0 && pd_sync_q[1];
    endsequence

    sequence frame_open_s;
        state_q == PDC_IDLE && le_fall;
    endsequence

    sequence frame_close_s;
        state_q == PDC_SHIFT && le_rise;
    endsequence

    // short frames are refused even when their select bits read zero
    sequence short_end_s;
        state_q == PDC_SHIFT && le_rise && count_q != `PDC_FRAME_COUNT && pd_sync_q[1];
    endsequence

    // loading and word selection
    word_load_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        frame_end_s |=> word0_q == $past(shift_q))
        else $error("word zero not loaded");
    word_sel_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (le_rise && shift_q[1:0] != 2'h0 && pd_sync_q[1]) |=> $stable(word0_q))
        else $error("other word changed word zero");
    sel_keep_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        word0_q.word_select == 2'h0)
        else $error("word zero holds a foreign select");
    short_drop_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        short_end_s |=> $stable(word0_q))
        else $error("short frame reached word zero");
    idle_hold_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (state_q == PDC_IDLE && pd_sync_q[1]) |=> $stable(word0_q))
        else $error("word zero changed outside a frame");

    // power-down restores every field to its power-up value
    pd_default_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !pd_sync_q[1] |=> word0_q == `PDC_WORD0_RST)
        else $error("power-down default lost");
    prediv_rst_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !pd_sync_q[1] |=> word0_q.ref_prediv == `PDC_PREDIV_RST)
        else $error("prediv default wrong");
    fbdiv_rst_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !pd_sync_q[1] |=> word0_q.fb_div == `PDC_FBDIV_RST)
        else $error("fb divider default wrong");
    delay_rst_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !pd_sync_q[1] |=> word0_q.ref_phase_delay == `PDC_DLY_RST && word0_q.fb_phase_delay == `PDC_DLY_RST)
        else $error("delay default wrong");
    mode_rst_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !pd_sync_q[1] |=> !word0_q.ref_select_auto && !word0_q.ref_freq_detect_disable)
        else $error("mode default wrong");

    // reference status pin
    status_force_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        word0_q.ref_freq_detect_disable |=> ref_status_o)
        else $error("status not forced high");
    status_follow_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !word0_q.ref_freq_detect_disable |=> ref_status_o == $past(valid_sync_q[1]))
        else $error("status not following monitor");

    // shifting, bit counting and framing
    shift_msb_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (state_q == PDC_SHIFT && clk_rise && !le_sync_q[1]) |=> shift_q[0] == $past(data_sync_q[1]))
        else $error("serial bit not shifted in");
    count_step_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (state_q == PDC_SHIFT && clk_rise && !le_sync_q[1] && count_q != `PDC_FRAME_COUNT)
        |=> count_q == $past(count_q) + 6'h01)
        else $error("bit count did not advance");
    count_cap_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        count_q <= `PDC_FRAME_COUNT)
        else $error("bit count passed a full word");
    idle_shift_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        state_q == PDC_IDLE |=> $stable(shift_q))
        else $error("shift register moved outside a frame");
    frame_open_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        frame_open_s |=> state_q == PDC_SHIFT && count_q == 6'h00)
        else $error("frame did not open cleanly");
    frame_close_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        frame_close_s |=> state_q == PDC_IDLE)
        else $error("frame did not close");
    frame_stay_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (state_q == PDC_SHIFT && !le_rise) |=> state_q == PDC_SHIFT)
        else $error("frame left without latch rise");
endmodule : pdc_config_word

/* File: hw/pdc_params.svh */
/*
 Frame bit count, field positions and reset values for the divider/delay configuration word.
 Assumes inclusion by pdc_pkg.sv and the top module only.
*/
`ifndef PDC_PARAMS_SVH
`define PDC_PARAMS_SVH
`define PDC_WORD_BITS 32
`define PDC_FRAME_COUNT 6'h20
`define PDC_SEL_LSB 0
`define PDC_SEL_WORD0 2'h0
`define PDC_PREDIV_LSB 2
`define PDC_PREDIV_MSB 11
`define PDC_FBDIV_LSB 12
`define PDC_FBDIV_MSB 23
`define PDC_REFDLY_LSB 24
`define PDC_REFDLY_MSB 26
`define PDC_FBDLY_LSB 27
`define PDC_FBDLY_MSB 29
`define PDC_AUTO_BIT 30
`define PDC_DETDIS_BIT 31
`define PDC_PREDIV_RST 10'h07F
`define PDC_FBDIV_RST 12'h07F
`define PDC_DLY_RST 3'h0
`define PDC_WORD0_RST 32'h0007F1FC
`endif

/* File: hw/pdc_pkg.sv */
/*
 Types for the divider/delay configuration word.
 Assumes pdc_params.svh is on the include path.
*/
`include "pdc_params.svh"
package pdc_pkg;
    // field layout of word zero, msb first
    typedef struct packed {
        logic ref_freq_detect_disable;
        logic ref_select_auto;
        logic [2:0] fb_phase_delay;
        logic [2:0] ref_phase_delay;
        logic [11:0] fb_div;
        logic [9:0] ref_prediv;
        logic [1:0] word_select;
    } pdc_word0_type;
    typedef enum logic [0:0] {
        PDC_IDLE,
        PDC_SHIFT
    } pdc_state_type;
endpackage : pdc_pkg

/* File: bench/pdc_cfg_host.sv */
/*
 Serial configuration host model: frames one word on the three serial lines.
 Assumes its timing is unrelated in phase to the block's system clock.
*/
`timescale 1ns/10ps
module pdc_cfg_host (
    output logic cfg_clk_o, // serial clock, low outside frames
    output logic cfg_data_o, // serial data, pulled high when idle
    output logic cfg_latch_enable_o // frame line, high when idle
);
    initial begin
        cfg_clk_o = 1'b0;
        cfg_data_o = 1'b1;
        cfg_latch_enable_o = 1'b1;
    end
    // n clocks msb first; n above 32 repeats low bits first so the last 32 are the word
    task automatic send(input logic [31:0] w, input int n);
        // one ns off the system clock grid so no serial edge races a sampling edge
        #101 cfg_latch_enable_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            cfg_data_o = w[i % 32];
            #62.5 cfg_clk_o = 1'b1;
            #62.5 cfg_clk_o = 1'b0;
        end
        // line released: the pull-up wins, not the last bit
        #60 cfg_data_o = 1'b1;
        cfg_latch_enable_o = 1'b1;
        #100;
    endtask : send
endmodule : pdc_cfg_host

/* File: bench/tb_pll_divider_delay_config_word.sv */
/*
 Self-checking bench for configuration word zero and the reference status pin.
 Assumes the serial host model drives the serial lines; all else is driven here.
*/
`timescale 1ns/10ps
module tb_pll_divider_delay_config_word;
    import pdc_pkg::*;
    logic mclk_i;
    logic sys_rst_i;
    logic power_down_n_i;
    logic ref_valid_i;
    logic cfg_clk;
    logic cfg_data;
    logic cfg_le;
    pdc_word0_type word0_o;
    logic ref_status_o;
    int error_cnt = 0;
    int checks_done = 0;
    // defaults built field by field, not copied from the design
    localparam logic [31:0] DEF = {1'b0, 1'b0, 3'h0, 3'h0, 12'h07F, 10'h07F, 2'h0};
    // divider values assume the host's feedback prescale keeps the divider input in range
    localparam logic [31:0] W1 = {1'b1, 1'b1, 3'h5, 3'h2, 12'hABC, 10'h155, 2'h0};
    localparam logic [31:0] W2 = {1'b0, 1'b0, 3'h2, 3'h5, 12'h543, 10'h2AA, 2'h0};
    pdc_cfg_host i_pdc_cfg_host (.cfg_clk_o(cfg_clk), .cfg_data_o(cfg_data), .cfg_latch_enable_o(cfg_le));
    pdc_config_word i_pdc_config_word (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cfg_clk_i(cfg_clk),
        .cfg_data_i(cfg_data), .cfg_latch_enable_i(cfg_le), .power_down_n_i(power_down_n_i),
        .ref_valid_i(ref_valid_i), .word0_o(word0_o), .ref_status_o(ref_status_o));
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : cyc
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    // one frame, then enough cycles for the sync and load lag to settle
    task automatic wr(input logic [31:0] w, input int n);
        i_pdc_cfg_host.send(w, n);
        cyc(10);
    endtask : wr
    // watchdog: all frames together take well under 100 us
    initial begin
        #300000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        sys_rst_i = 1'b1;
        power_down_n_i = 1'b1;
        ref_valid_i = 1'b1;
        cyc(16);
        sys_rst_i <= 1'b0;
        cyc(8);
        chk(word0_o, DEF);
        chk(ref_status_o, 1'b1);
        ref_valid_i <= 1'b0;
        cyc(6);
        chk(ref_status_o, 1'b0);
        wr(W1, 32);
        chk(word0_o, W1);
        chk(ref_status_o, 1'b1);
        wr(W2, 33);
        chk(word0_o, W2);
        chk(ref_status_o, 1'b0);
        // other word selects must leave word zero alone
        for (int s = 1; s < 4; s++) begin
            wr(W1 | 32'(s), 32);
            chk(word0_o, W2);
        end
        wr(W1, 31);
        chk(word0_o, W2);
        ref_valid_i <= 1'b1;
        cyc(6);
        chk(ref_status_o, 1'b1);
        power_down_n_i <= 1'b0;
        cyc(8);
        chk(word0_o, DEF);
        wr(W1, 32);
        chk(word0_o, DEF);
        power_down_n_i <= 1'b1;
        cyc(8);
        chk(word0_o, DEF);
        wr(W1, 32);
        chk(word0_o, W1);
        sys_rst_i <= 1'b1;
        cyc(2);
        sys_rst_i <= 1'b0;
        cyc(8);
        chk(word0_o, DEF);
        report_and_stop();
    end
endmodule : tb_pll_divider_delay_config_word
